// file: rtl/ims_pkg.sv
// Package with constants and types of the impedance meter bus master.
package ims_pkg;
   // System clock period in nanoseconds.
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Least time of one quarter of a serial clock period, in ns.
   localparam int unsigned SCL_QUARTER_NS = 2500;
   // Quarter period in system clock cycles, rounded up.
   localparam int unsigned QUARTER_CYC =
      (SCL_QUARTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Slave address of the converter after power-up.
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h0d;
   // Direction bit values.
   localparam logic DIR_WRITE = 1'b0;
   localparam logic DIR_READ  = 1'b1;
   // Command codes.
   localparam logic [7:0] CMD_BLOCK_WRITE = 8'ha0;
   localparam logic [7:0] CMD_BLOCK_READ  = 8'ha1;
   localparam logic [7:0] CMD_POINTER     = 8'hb0;
   // Index of the acknowledge bit within a byte slot.
   localparam logic [3:0] ACK_BIT_IDX = 4'h8;
   // User operation codes on the command port.
   localparam logic [2:0] OP_WRITE_REG   = 3'h0;
   localparam logic [2:0] OP_SET_POINTER = 3'h1;
   localparam logic [2:0] OP_BLOCK_WRITE = 3'h2;
   localparam logic [2:0] OP_READ_BYTE   = 3'h3;
   localparam logic [2:0] OP_BLOCK_READ  = 3'h4;
   // Bus symbol kinds handled by the bit engine.
   typedef enum logic [1:0] {KIND_START, KIND_STOP, KIND_BIT} ims_kind_t;
   // Steps of an operation sequence.
   typedef enum logic [3:0] {
      ACT_START, ACT_STOP, ACT_ADDRW, ACT_ADDRR, ACT_PTR, ACT_REG,
      ACT_DATA, ACT_BWCMD, ACT_BRCMD, ACT_COUNT, ACT_WSTREAM,
      ACT_RSTREAM, ACT_END
   } ims_act_t;
endpackage

// file: rtl/ims_bit_if.sv
// Interface between the byte sequencer and the bit engine.
`timescale 1ns/10ps
interface ims_bit_if;
   logic                req;   // One-cycle request for a symbol.
   ims_pkg::ims_kind_t  kind;  // Symbol kind.
   logic                txBit; // Bit to send, 1 releases the line.
   logic                done;  // One-cycle end of symbol.
   logic                rxBit; // Line level sampled in the bit.
   modport ctrl (output req, kind, txBit, input done, rxBit);
   modport eng (input req, kind, txBit, output done, rxBit);
endinterface

// file: rtl/ims_bit_engine.sv
// Bit engine: makes start, stop and data bit symbols on the two wires.
`timescale 1ns/10ps
module ims_bit_engine (
   input  wire logic clk_sys, // System clock.
   input  wire logic reset,   // Synchronous reset, active high.
   input  wire logic clkEn,   // Clock enable.
   ims_bit_if.eng    bus,     // Symbol requests.
   input  wire logic sdaIn,   // Data line level.
   output logic      sdaOut,  // Data line drive value.
   output logic      sdaOeN,  // Data line enable, low drives.
   input  wire logic sclIn,   // Clock line level.
   output logic      sclOut,  // Clock line drive value.
   output logic      sclOeN   // Clock line enable, low drives.
);
   typedef enum logic {ENG_IDLE, ENG_RUN} ims_eng_t;
   localparam logic [15:0] Q_LAST = 16'(ims_pkg::QUARTER_CYC - 1);

   ims_eng_t           st_reg;    // Engine state.
   ims_pkg::ims_kind_t kind_reg;  // Symbol in progress.
   logic               tx_reg;    // Bit in progress.
   logic [1:0]         phase_reg; // Quarter of the symbol.
   logic [15:0]        tick_reg;  // Cycles within the quarter.
   logic [2:0]         sdaS_reg;  // Data line synchroniser.
   logic [2:0]         sclS_reg;  // Clock line synchroniser.
   logic               sdaL_reg;  // Filtered data level.
   logic               sclL_reg;  // Filtered clock level.
   logic               done_reg;  // End of symbol pulse.
   logic               rx_reg;    // Sampled bit.
   logic               sdaRel;    // Data line released.
   logic               sclRel;    // Clock line released.
   logic               stretch;   // Slave holds the clock low.
   logic               qEnd;      // Quarter complete.

   // Clock high in the middle quarters; for stop it stays high after
   // the first. Data moves only in quarter 0, or in quarter 2 for start and stop.
   assign sclRel = (kind_reg == ims_pkg::KIND_STOP) ? (phase_reg != 2'h0)
                 : (phase_reg == 2'h1) || (phase_reg == 2'h2);
   assign sdaRel = (kind_reg == ims_pkg::KIND_START) ? (phase_reg < 2'h2)
                 : (kind_reg == ims_pkg::KIND_STOP) ? (phase_reg >= 2'h2)
                 : tx_reg;
   assign stretch = (phase_reg == 2'h1) && !sclL_reg;
   assign qEnd    = (tick_reg == Q_LAST) && !stretch;
   assign bus.done  = done_reg;
   assign bus.rxBit = rx_reg;

   // Pin synchronisers; a level counts once stages two and three agree.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sdaS_reg <= 3'h7;
         sclS_reg <= 3'h7;
         sdaL_reg <= 1'b1;
         sclL_reg <= 1'b1;
      end else if (clkEn) begin
         sdaS_reg <= {sdaS_reg[1:0], sdaIn};
         sclS_reg <= {sclS_reg[1:0], sclIn};
         if (sdaS_reg[1] == sdaS_reg[2]) sdaL_reg <= sdaS_reg[2];
         if (sclS_reg[1] == sclS_reg[2]) sclL_reg <= sclS_reg[2];
      end
   end

   // Symbol sequencer: four quarters, the bit sampled after quarter 2.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg <= ENG_IDLE;
         kind_reg <= ims_pkg::KIND_STOP;
         tx_reg <= 1'b1;
         phase_reg <= 2'h0;
         tick_reg <= 16'h0000;
         done_reg <= 1'b0;
         rx_reg <= 1'b1;
         sdaOut <= 1'b0;
         sclOut <= 1'b0;
         sdaOeN <= 1'b1;
         sclOeN <= 1'b1;
      end else if (clkEn) begin
         done_reg <= 1'b0;
         unique case (st_reg)
            ENG_IDLE: begin
               if (bus.req) begin
                  st_reg <= ENG_RUN;
                  kind_reg <= bus.kind;
                  tx_reg <= bus.txBit;
                  phase_reg <= 2'h0;
                  tick_reg <= 16'h0000;
               end
            end
            ENG_RUN: begin
               sdaOeN <= sdaRel;
               sclOeN <= sclRel;
               if (qEnd) begin
                  tick_reg <= 16'h0000;
                  if (phase_reg == 2'h2) rx_reg <= sdaL_reg;
                  if (phase_reg == 2'h3) begin
                     done_reg <= 1'b1;
                     st_reg <= ENG_IDLE;
                  end else begin
                     phase_reg <= phase_reg + 2'h1;
                  end
               end else if (tick_reg != Q_LAST) begin
                  tick_reg <= tick_reg + 16'h0001;
               end
            end
         endcase
      end
   end
endmodule // ims_bit_engine

// file: rtl/ims_i2c_master.sv
// Bus master that runs register transfers to the impedance converter.
`timescale 1ns/10ps
module ims_i2c_master #(
   parameter logic [6:0] DEV_ADDR = ims_pkg::DEV_ADDR_DEFAULT // Target.
) (
   input  wire logic       clk_sys,  // System clock.
   input  wire logic       reset,    // Synchronous reset.
   input  wire logic       clkEn,    // Clock enable.
   input  wire logic       cmdValid, // Operation request.
   input  wire logic [2:0] cmdOp,    // Operation code.
   input  wire logic [7:0] cmdReg,   // Register address.
   input  wire logic [7:0] cmdData,  // Data for a register write.
   input  wire logic [7:0] cmdCount, // Block length, 0 means 1.
   output logic            cmdReady, // Ready for an operation.
   input  wire logic       wrValid,  // Block write byte offered.
   input  wire logic [7:0] wrData,   // Block write byte.
   output logic            wrReady,  // Block write byte wanted.
   output logic            rdValid,  // Read byte pulse.
   output logic [7:0]      rdData,   // Read byte.
   output logic            rdLast,   // Last byte of the read.
   output logic            busy,     // Operation in progress.
   output logic            done,     // Operation finished pulse.
   output logic            ackErr,   // Slave refused a byte.
   input  wire logic       sdaIn,    // Data line level.
   output logic            sdaOut,   // Data line drive value.
   output logic            sdaOeN,   // Data line enable, low drives.
   input  wire logic       sclIn,    // Clock line level.
   output logic            sclOut,   // Clock line drive value.
   output logic            sclOeN    // Clock line enable, low drives.
);
   typedef enum logic [2:0] {
      T_IDLE, T_ACT, T_COND, T_WAITWR, T_BIT, T_WAITBIT
   } ims_state_t;

   ims_bit_if bitBus ();

   ims_state_t        st_reg;     // Sequencer state.
   logic [2:0]        op_reg;     // Operation in progress.
   logic [3:0]        step_reg;   // Step within the operation.
   logic [7:0]        regA_reg;   // Register address.
   logic [7:0]        data_reg;   // Register write data.
   logic [7:0]        count_reg;  // Block length sent.
   logic [7:0]        remain_reg; // Data bytes still to move.
   logic [7:0]        shift_reg;  // Byte shifter.
   logic [3:0]        bitIdx_reg; // Bit slot within the byte.
   logic              isRd_reg;   // Byte is received.
   logic              last_reg;   // Byte is the last read.
   logic              abort_reg;  // Ending after a refusal.
   logic              req_reg;    // Symbol request pulse.
   ims_pkg::ims_kind_t kind_reg;  // Symbol kind requested.
   logic              txBit_reg;  // Bit requested.
   logic              cmdRdy_reg; // Ready output.
   logic              wrRdy_reg;  // Write stream ready.
   logic              rdV_reg;    // Read valid pulse.
   logic [7:0]        rdD_reg;    // Read data.
   logic              rdL_reg;    // Read last flag.
   logic              busy_reg;   // Busy output.
   logic              done_reg;   // Done pulse.
   logic              err_reg;    // Refusal flag.

   ims_pkg::ims_act_t act;        // Current step.
   logic [7:0]        txByte;     // Byte for a sending step.
   logic              isTxAct;    // Step sends a fixed byte.
   logic [7:0]        countEff;   // Block length, zero as one.
   logic              bitTx;      // Bit to put in the slot.
   logic              inAck;      // Slot is the acknowledge.

   // Step table: a pointer write precedes all but the register write.
   function automatic ims_pkg::ims_act_t actAt(input logic [2:0] op,
                                               input logic [3:0] st);
      ims_pkg::ims_act_t a;
      logic wr;
      logic bw;
      logic rb;
      logic br;
      wr = (op == ims_pkg::OP_WRITE_REG);
      bw = (op == ims_pkg::OP_BLOCK_WRITE);
      rb = (op == ims_pkg::OP_READ_BYTE);
      br = (op == ims_pkg::OP_BLOCK_READ);
      unique case (st)
         4'h0: a = ims_pkg::ACT_START;
         4'h1: a = ims_pkg::ACT_ADDRW;
         4'h2: a = wr ? ims_pkg::ACT_REG : ims_pkg::ACT_PTR;
         4'h3: a = wr ? ims_pkg::ACT_DATA : ims_pkg::ACT_REG;
         4'h4: a = ims_pkg::ACT_STOP;
         4'h5: a = (bw || rb || br) ? ims_pkg::ACT_START : ims_pkg::ACT_END;
         4'h6: a = rb ? ims_pkg::ACT_ADDRR : ims_pkg::ACT_ADDRW;
         4'h7: a = rb ? ims_pkg::ACT_RSTREAM
                 : bw ? ims_pkg::ACT_BWCMD : ims_pkg::ACT_BRCMD;
         4'h8: a = rb ? ims_pkg::ACT_STOP : ims_pkg::ACT_COUNT;
         4'h9: a = bw ? ims_pkg::ACT_WSTREAM
                 : br ? ims_pkg::ACT_START : ims_pkg::ACT_END;
         4'ha: a = bw ? ims_pkg::ACT_STOP
                 : br ? ims_pkg::ACT_ADDRR : ims_pkg::ACT_END;
         4'hb: a = br ? ims_pkg::ACT_RSTREAM : ims_pkg::ACT_END;
         4'hc: a = br ? ims_pkg::ACT_STOP : ims_pkg::ACT_END;
         default: a = ims_pkg::ACT_END;
      endcase
      // Unknown operation codes end at once.
      if (!(wr || bw || rb || br || op == ims_pkg::OP_SET_POINTER)) begin
         a = ims_pkg::ACT_END;
      end
      return a;
   endfunction

   assign act      = actAt(op_reg, step_reg);
   assign countEff = (cmdCount == 8'h00) ? 8'h01 : cmdCount;
   assign inAck    = (bitIdx_reg == ims_pkg::ACK_BIT_IDX);

   // Fixed byte of each sending step.
   always_comb begin
      txByte  = 8'h00;
      isTxAct = 1'b1;
      unique case (act)
         ims_pkg::ACT_ADDRW: txByte = {DEV_ADDR, ims_pkg::DIR_WRITE};
         ims_pkg::ACT_ADDRR: txByte = {DEV_ADDR, ims_pkg::DIR_READ};
         ims_pkg::ACT_PTR:   txByte = ims_pkg::CMD_POINTER;
         ims_pkg::ACT_BWCMD: txByte = ims_pkg::CMD_BLOCK_WRITE;
         ims_pkg::ACT_BRCMD: txByte = ims_pkg::CMD_BLOCK_READ;
         ims_pkg::ACT_REG:   txByte = regA_reg;
         ims_pkg::ACT_DATA:  txByte = data_reg;
         ims_pkg::ACT_COUNT: txByte = count_reg;
         default:            isTxAct = 1'b0;
      endcase
   end

   // Bit for the slot: data MSB first, then the acknowledge slot.
   // On reads the line is released for data and we answer the
   // acknowledge: low for more bytes, released after the last.
   assign bitTx = !inAck ? (isRd_reg | shift_reg[7])
                : (isRd_reg ? last_reg : 1'b1);

   assign bitBus.req   = req_reg;
   assign bitBus.kind  = kind_reg;
   assign bitBus.txBit = txBit_reg;

   // Outputs come straight from their flip-flops.
   assign cmdReady = cmdRdy_reg;
   assign wrReady  = wrRdy_reg;
   assign rdValid  = rdV_reg;
   assign rdData   = rdD_reg;
   assign rdLast   = rdL_reg;
   assign busy     = busy_reg;
   assign done     = done_reg;
   assign ackErr   = err_reg;

   // Byte sequencer: walks the steps and feeds the bit engine.
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st_reg <= T_IDLE;
         op_reg <= ims_pkg::OP_WRITE_REG;
         step_reg <= 4'h0;
         regA_reg <= 8'h00;
         data_reg <= 8'h00;
         count_reg <= 8'h00;
         remain_reg <= 8'h00;
         shift_reg <= 8'h00;
         bitIdx_reg <= 4'h0;
         isRd_reg <= 1'b0;
         last_reg <= 1'b0;
         abort_reg <= 1'b0;
         req_reg <= 1'b0;
         kind_reg <= ims_pkg::KIND_STOP;
         txBit_reg <= 1'b1;
         cmdRdy_reg <= 1'b0;
         wrRdy_reg <= 1'b0;
         rdV_reg <= 1'b0;
         rdD_reg <= 8'h00;
         rdL_reg <= 1'b0;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end else if (clkEn) begin
         // Pulses last one enabled cycle.
         req_reg <= 1'b0;
         rdV_reg <= 1'b0;
         done_reg <= 1'b0;
         unique case (st_reg)
            // Wait for an operation; ready rises one cycle after reset.
            T_IDLE: begin
               cmdRdy_reg <= 1'b1;
               if (cmdValid && cmdRdy_reg) begin
                  cmdRdy_reg <= 1'b0;
                  busy_reg <= 1'b1;
                  err_reg <= 1'b0;
                  abort_reg <= 1'b0;
                  op_reg <= cmdOp;
                  regA_reg <= cmdReg;
                  data_reg <= cmdData;
                  count_reg <= countEff;
                  remain_reg <= (cmdOp == ims_pkg::OP_READ_BYTE) ? 8'h01
                              : countEff;
                  step_reg <= 4'h0;
                  st_reg <= T_ACT;
               end
            end
            // Start the current step.
            T_ACT: begin
               if (act == ims_pkg::ACT_END) begin
                  busy_reg <= 1'b0;
                  done_reg <= 1'b1;
                  cmdRdy_reg <= 1'b1;
                  st_reg <= T_IDLE;
               end else if (act == ims_pkg::ACT_START) begin
                  req_reg <= 1'b1;
                  kind_reg <= ims_pkg::KIND_START;
                  st_reg <= T_COND;
               end else if (act == ims_pkg::ACT_STOP) begin
                  req_reg <= 1'b1;
                  kind_reg <= ims_pkg::KIND_STOP;
                  st_reg <= T_COND;
               end else if (isTxAct) begin
                  shift_reg <= txByte;
                  isRd_reg <= 1'b0;
                  bitIdx_reg <= 4'h0;
                  st_reg <= T_BIT;
               end else if (remain_reg == 8'h00) begin
                  // Stream exhausted: move past it.
                  step_reg <= step_reg + 4'h1;
               end else if (act == ims_pkg::ACT_WSTREAM) begin
                  st_reg <= T_WAITWR;
               end else begin
                  isRd_reg <= 1'b1;
                  last_reg <= (remain_reg == 8'h01);
                  bitIdx_reg <= 4'h0;
                  st_reg <= T_BIT;
               end
            end
            // Wait for a start or stop to finish.
            T_COND: begin
               if (bitBus.done) begin
                  if (abort_reg) begin
                     busy_reg <= 1'b0;
                     done_reg <= 1'b1;
                     cmdRdy_reg <= 1'b1;
                     st_reg <= T_IDLE;
                  end else begin
                     step_reg <= step_reg + 4'h1;
                     st_reg <= T_ACT;
                  end
               end
            end
            // Take one block write byte; the source may stall us here.
            T_WAITWR: begin
               if (wrRdy_reg && wrValid) begin
                  wrRdy_reg <= 1'b0;
                  shift_reg <= wrData;
                  isRd_reg <= 1'b0;
                  bitIdx_reg <= 4'h0;
                  st_reg <= T_BIT;
               end else begin
                  wrRdy_reg <= 1'b1;
               end
            end
            // Request one bit slot.
            T_BIT: begin
               req_reg <= 1'b1;
               kind_reg <= ims_pkg::KIND_BIT;
               txBit_reg <= bitTx;
               st_reg <= T_WAITBIT;
            end
            // Collect the slot; after nine slots the byte is done.
            T_WAITBIT: begin
               if (bitBus.done) begin
                  if (!inAck) begin
                     shift_reg <= {shift_reg[6:0], bitBus.rxBit};
                     bitIdx_reg <= bitIdx_reg + 4'h1;
                     st_reg <= T_BIT;
                  end else if (!isRd_reg && bitBus.rxBit) begin
                     // No acknowledge from the slave: stop and report.
                     err_reg <= 1'b1;
                     abort_reg <= 1'b1;
                     req_reg <= 1'b1;
                     kind_reg <= ims_pkg::KIND_STOP;
                     st_reg <= T_COND;
                  end else begin
                     if (isRd_reg) begin
                        rdV_reg <= 1'b1;
                        rdD_reg <= shift_reg;
                        rdL_reg <= last_reg;
                     end
                     if (act == ims_pkg::ACT_WSTREAM ||
                         act == ims_pkg::ACT_RSTREAM) begin
                        // The slave steps its own address per byte.
                        remain_reg <= remain_reg - 8'h01;
                     end else begin
                        step_reg <= step_reg + 4'h1;
                     end
                     st_reg <= T_ACT;
                  end
               end
            end
            default: st_reg <= T_IDLE;
         endcase
      end
   end

   // Pin engine; its pin outputs are flip-flops.
   ims_bit_engine u_engine (
      .clk_sys (clk_sys),
      .reset   (reset),
      .clkEn   (clkEn),
      .bus     (bitBus.eng),
      .sdaIn   (sdaIn),
      .sdaOut  (sdaOut),
      .sdaOeN  (sdaOeN),
      .sclIn   (sclIn),
      .sclOut  (sclOut),
      .sclOeN  (sclOeN)
   );
endmodule // ims_i2c_master

// file: testbench/ims_i2c_master_checker.sv
// Checker of the command, stream and line behaviour of the bus master.
`timescale 1ns/10ps
module ims_i2c_master_checker (
   input wire logic       clk_sys,  // System clock.
   input wire logic       reset,    // Reset.
   input wire logic       clkEn,    // Clock enable.
   input wire logic       cmdValid, // Request.
   input wire logic [2:0] cmdOp,    // Operation.
   input wire logic       cmdReady, // Idle.
   input wire logic       busy,     // Busy.
   input wire logic       done,     // End pulse.
   input wire logic       wrValid,  // Write byte offered.
   input wire logic       wrReady,  // Write byte wanted.
   input wire logic       rdValid,  // Read byte pulse.
   input wire logic       sdaOeN,   // Data enable.
   input wire logic       sclOeN    // Clock enable of the line.
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (reset);
   a_take_busy: assert property (clkEn && cmdValid && cmdReady |=> busy && !cmdReady)
      else $error("take did not start busy");
   a_ready_idle: assert property (cmdReady |-> !busy)
      else $error("ready while busy");
   a_done_ready: assert property (done |-> cmdReady && !busy)
      else $error("done without ready");
   a_done_pulse: assert property (done |=> !done)
      else $error("done longer than a cycle");
   a_idle_release: assert property (cmdReady |-> sdaOeN && sclOeN)
      else $error("line driven while idle");
   a_wr_drop: assert property (clkEn && wrValid && wrReady |=> !wrReady)
      else $error("write byte wanted twice");
   a_rd_pulse: assert property (rdValid |=> !rdValid)
      else $error("read pulse too long");
   a_start_first: assert property (clkEn && cmdValid && cmdReady && cmdOp < 3'h5
      |=> sdaOeN [*8])
      else $error("data pulled before start");
endmodule // ims_i2c_master_checker

bind ims_i2c_master ims_i2c_master_checker u_ims_i2c_master_checker (.clk_sys, .reset,
   .clkEn, .cmdValid, .cmdOp, .cmdReady, .busy, .done, .wrValid, .wrReady, .rdValid,
   .sdaOeN, .sclOeN);

// file: testbench/ims_slave_model.sv
// Behavioural model of the converter's serial slave port and its registers.
`timescale 1ns/10ps
module ims_slave_model (
   input wire logic       scl,    // Clock line level.
   input wire logic       sda,    // Data line level.
   input wire logic [6:0] addr,   // Own address.
   output logic           sdaOeN  // Data enable, low pulls down.
);
   logic [7:0] mem [256]; // Register space.
   logic [7:0] sh, cmd, ptr;
   logic       rd, sel, blk, mack;
   int         bitN, byteN;
   initial begin sdaOeN = 1'b1; sel = 1'b0; blk = 1'b0; bitN = 0; byteN = 0; end
   // Start or repeated start: the following clock fall opens bit zero.
   always @(negedge sda) if (scl) begin bitN = -1; byteN = 0; sdaOeN = 1'b1; end
   // Stop deselects.
   always @(posedge sda) if (scl) begin sel = 1'b0; blk = 1'b0; end
   // Bits in, then the master's acknowledge.
   always @(posedge scl) if (bitN < 8) sh = {sh[6:0], sda}; else mack = sda;
   // Command byte, pointer and register writes.
   task automatic write_byte();
      if (byteN == 1) begin
         cmd = sh;
         if (sh == ims_pkg::CMD_BLOCK_WRITE || sh == ims_pkg::CMD_BLOCK_READ) blk = 1'b1;
         else if (sh != ims_pkg::CMD_POINTER) ptr = sh;
      end else if (byteN == 2 && cmd == ims_pkg::CMD_POINTER) ptr = sh;
      else if (byteN == 2 && !blk) mem[ptr] = sh;
      else if (byteN > 2 && cmd == ims_pkg::CMD_BLOCK_WRITE) begin
         mem[ptr] = sh;
         ptr++;
      end
   endtask
   // The line only changes while the clock is low.
   always @(negedge scl) begin
      bitN++;
      if (bitN == 8) begin
         if (byteN == 0) begin sel = (sh[7:1] == addr); rd = sh[0]; end
         else if (sel && !rd) write_byte();
         sdaOeN = !(sel && (!rd || byteN == 0));
      end else if (bitN == 9) begin
         bitN = 0;
         byteN++;
         sdaOeN = 1'b1;
         if (sel && rd && blk && byteN > 1 && !mack) ptr++;
      end
      if (sel && rd && byteN > 0 && bitN < 8 && (byteN == 1 || !mack))
         sdaOeN = mem[ptr][7 - bitN];
   end
endmodule // ims_slave_model

// file: testbench/tb_ims_i2c_master.sv
// Testbench of the bus master against the slave model.
`timescale 1ns/10ps
module tb_ims_i2c_master;
   logic       clk_sys = 1'b0; // System clock.
   logic       reset = 1'b1;   // Reset.
   logic       cmdValid = 1'b0;
   logic [2:0] cmdOp = 3'h0;
   logic [7:0] cmdReg = 8'h00, cmdData = 8'h00, cmdCount = 8'h00, wrData = 8'h00;
   logic       wrValid = 1'b0;
   logic [6:0] devAddr = ims_pkg::DEV_ADDR_DEFAULT; // Model address.
   logic [7:0] rdBuf [4];
   logic [7:0] lastBuf [4];
   wire logic  cmdReady, wrReady, rdValid, rdLast, busy, done, ackErr, sdaOeN, sclOeN, slvOeN;
   wire logic  sdaOut, sclOut; // Line drive values, always low.
   wire logic [7:0] rdData;
   wire logic  sda = sdaOeN & slvOeN; // Pulled up line.
   int         n_mismatch = 0, checks = 0, nr;
   always #25 clk_sys = ~clk_sys;
   ims_i2c_master u_ims_i2c_master (.clk_sys, .reset, .clkEn(1'b1), .cmdValid, .cmdOp,
      .cmdReg, .cmdData, .cmdCount, .cmdReady, .wrValid, .wrData, .wrReady, .rdValid,
      .rdData, .rdLast, .busy, .done, .ackErr, .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN,
      .sclIn(sclOeN), .sclOut(sclOut), .sclOeN);
   ims_slave_model u_ims_slave_model (.scl(sclOeN), .sda, .addr(devAddr), .sdaOeN(slvOeN));
   task automatic check(input string what, input logic [7:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Runs one operation, feeds 8'h11 then 8'h22 to a block write, collects read bytes.
   task automatic run(input logic [2:0] op, input logic [7:0] r, d, c);
      int n, wi;
      logic took, rdv;
      n = 0;
      wi = 0;
      nr = 0;
      @(posedge clk_sys); #1;
      cmdOp = op; cmdReg = r; cmdData = d; cmdCount = c; cmdValid = 1'b1;
      wrValid = (op == ims_pkg::OP_BLOCK_WRITE);
      wrData = 8'h11;
      took = 1'b0;
      // Hold the request until an edge that sees ready high.
      while (!took && n < 40000) begin
         took = (cmdReady === 1'b1);
         @(posedge clk_sys); #1;
         n++;
      end
      cmdValid = 1'b0;
      while (done !== 1'b1 && n < 40000) begin
         took = wrValid && wrReady;
         rdv = rdValid;
         @(posedge clk_sys); #1;
         if (took) begin wi++; wrData = 8'h22; wrValid = (wi < 2); end
         if (rdv === 1'b1 && nr < 4) begin rdBuf[nr] = rdData; lastBuf[nr] = {7'h0, rdLast}; nr++; end
         n++;
      end
      check("done", {7'h0, done}, 8'h01);
      check("lineOut", {6'h00, sdaOut, sclOut}, 8'h00);
   endtask
   task automatic final_report();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (100000) @(posedge clk_sys);
      n_mismatch++;
      final_report();
   end
   initial begin
      repeat (4) @(posedge clk_sys); #1;
      reset = 1'b0;
      run(ims_pkg::OP_WRITE_REG, 8'h80, 8'h5a, 8'h00);
      check("ackErr", {7'h0, ackErr}, 8'h00);
      run(ims_pkg::OP_SET_POINTER, 8'h81, 8'h00, 8'h00);
      check("ackErr", {7'h0, ackErr}, 8'h00);
      run(ims_pkg::OP_BLOCK_WRITE, 8'h82, 8'h00, 8'h02);
      check("ackErr", {7'h0, ackErr}, 8'h00);
      run(ims_pkg::OP_READ_BYTE, 8'h80, 8'h00, 8'h00);
      check("byte", rdBuf[0], 8'h5a);
      check("last", lastBuf[0], 8'h01);
      check("nRead", 8'(nr), 8'h01);
      run(ims_pkg::OP_BLOCK_READ, 8'h82, 8'h00, 8'h02);
      check("first", rdBuf[0], 8'h11);
      check("second", rdBuf[1], 8'h22);
      check("last", lastBuf[1], 8'h01);
      check("nRead", 8'(nr), 8'h02);
      devAddr = 7'h0e;
      run(ims_pkg::OP_WRITE_REG, 8'h80, 8'ha5, 8'h00);
      check("refused", {7'h0, ackErr}, 8'h01);
      devAddr = ims_pkg::DEV_ADDR_DEFAULT;
      run(3'h5, 8'h80, 8'h00, 8'h00);
      check("noop", {7'h0, ackErr}, 8'h00);
      run(ims_pkg::OP_READ_BYTE, 8'h80, 8'h00, 8'h00);
      check("kept", rdBuf[0], 8'h5a);
      final_report();
   end
endmodule // tb_ims_i2c_master
